//--- core/lfo_ctrl.v
// What this block does
// - oscillator runs only while enable bit set
// - ready bit six reads one once stable
// - ready clears only on reset, divider change
// - four-bit trim, zero fastest, ones slowest
// - two-bit divider: 8, 4, 2, 1
// - crystal, capacitor, RC drive or CMOS input
// - external setup only via its control register
// - crystal mode claims both oscillator pins
// - other active modes claim only second pin, off modes claim none
// - external clock offered to system, peripherals
// - three-bit mode field encodes seven settings
// - valid flag when stable, zero in CMOS
`timescale 1ns/10ps
`include "lfo_consts.vh"

module lfo_ctrl #(
  parameter STAB_EDGES = `LFO_STAB_EDGES,
  parameter [3:0] LF_TUNE_RST = `LFO_LF_TUNE_RST
) (
  input wire mclk,
  input wire rstn,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire lf_osc_raw,
  input wire ext_osc_raw,
  input wire ext_osc_stable,
  output reg lowfreq_osc_enable,
  output reg [3:0] lowfreq_fine_tune,
  output reg lowfreq_osc_ready,
  output reg lf_clk_out,
  output reg ext_drive_en,
  output reg [2:0] ext_osc_mode_select,
  output reg [2:0] ext_freq_ctrl,
  output reg ext_osc_valid_flag,
  output reg ext_osc_pin_a,
  output reg ext_osc_pin_b,
  output reg ext_clk_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [1:0] lowfreq_divider_select; // divide select field
  reg [15:0] stab_cnt_q; // lf edges since restart
  reg [2:0] div_cnt_q; // lf divider counter
  reg lf_raw_q; // previous lf level
  reg ext_raw_q; // previous external level
  reg ext_half_q; // external clock halved
  wire lf_wr; // write to lf control
  wire ext_wr; // write to external control
  wire lf_rise; // lf rising edge
  wire div_change; // divider field changes
  wire lf_restart; // enable turns on or divider changes
  wire stab_done; // counter reached target
  wire [1:0] new_div; // written divider value
  wire [2:0] new_mode; // mode as seen by logic
  reg ext_on; // any mode other than off, cmos included
  reg ext_cmos; // cmos input modes
  reg ext_xtal; // crystal or resonator modes
  reg ext_div2; // modes with halving stage
  reg lf_div_sel; // divided lf level
  reg [7:0] rd_mux; // read data mux

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign lf_wr = sfr_wr && (sfr_addr == `LFO_ADDR_LF_CTRL);
  assign ext_wr = sfr_wr && (sfr_addr == `LFO_ADDR_EXT_CTRL);
  assign new_div = sfr_wdata[`LFO_LF_DIV_HI:`LFO_LF_DIV_LO];
  assign div_change = lf_wr && (new_div != lowfreq_divider_select);
  // restart on enable or divider change
  assign lf_restart = div_change ||
    (lf_wr && sfr_wdata[`LFO_LF_EN_BIT] && !lowfreq_osc_enable);
  assign lf_rise = lf_osc_raw && !lf_raw_q;
  assign stab_done = (stab_cnt_q >= STAB_EDGES[15:0]);
  assign new_mode = ext_osc_mode_select;

  // ----------------------------------------------------------------
  // low-frequency control register
  // ----------------------------------------------------------------
  // enable, trim and divider fields, all writable
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lowfreq_osc_enable <= `LFO_LF_EN_RST;
      lowfreq_fine_tune <= LF_TUNE_RST;
      lowfreq_divider_select <= `LFO_LF_DIV_RST;
    end else if (lf_wr) begin
      lowfreq_osc_enable <= sfr_wdata[`LFO_LF_EN_BIT];
      // trim goes straight to the oscillator
      lowfreq_fine_tune <=
        sfr_wdata[`LFO_LF_TUNE_HI:`LFO_LF_TUNE_LO];
      lowfreq_divider_select <= new_div;
    end
  end

  // ----------------------------------------------------------------
  // stabilisation counter and ready flag
  // ----------------------------------------------------------------
  // counts lf rising edges while enabled, saturates at target
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stab_cnt_q <= 16'h0000;
      lf_raw_q <= 1'b0;
    end else begin
      lf_raw_q <= lf_osc_raw;
      // edge count from the lf oscillator
      if (lf_restart) begin
        stab_cnt_q <= 16'h0000;
      end else if (lowfreq_osc_enable && lf_rise && !stab_done) begin
        stab_cnt_q <= stab_cnt_q + 16'h0001;
      end
    end
  end

  // sticky ready; a divider change blocks the set, so the clear wins
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lowfreq_osc_ready <= 1'b0;
    end else if (stab_done && lowfreq_osc_enable && !lf_restart) begin
      lowfreq_osc_ready <= 1'b1;
    end else if (div_change) begin
      lowfreq_osc_ready <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // low-frequency output divider
  // ----------------------------------------------------------------
  // pick divided level from the counter bits
  always @* begin
    case (lowfreq_divider_select)
      `LFO_DIV_8: lf_div_sel = div_cnt_q[2];
      `LFO_DIV_4: lf_div_sel = div_cnt_q[1];
      `LFO_DIV_2: lf_div_sel = div_cnt_q[0];
      `LFO_DIV_1: lf_div_sel = lf_raw_q;
      default: lf_div_sel = lf_raw_q;
    endcase
  end

  // divider counter and registered output, idle when disabled
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= 3'h0;
      lf_clk_out <= 1'b0;
    end else begin
      if (!lowfreq_osc_enable) begin
        div_cnt_q <= 3'h0;
        lf_clk_out <= 1'b0;
      end else begin
        if (lf_rise) begin
          div_cnt_q <= div_cnt_q + 3'h1;
        end
        lf_clk_out <= lf_div_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // external oscillator control register
  // ----------------------------------------------------------------
  // mode and frequency fields; valid bit is read-only
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_osc_mode_select <= `LFO_EXT_MODE_RST;
      ext_freq_ctrl <= `LFO_EXT_FREQ_RST;
    end else if (ext_wr) begin
      // only this register configures the drive
      ext_osc_mode_select <=
        sfr_wdata[`LFO_EXT_MODE_HI:`LFO_EXT_MODE_LO];
      ext_freq_ctrl <= sfr_wdata[`LFO_EXT_FREQ_HI:`LFO_EXT_FREQ_LO];
    end
  end

  // ----------------------------------------------------------------
  // external mode decode
  // ----------------------------------------------------------------
  // seven settings of the mode field
  always @* begin
    ext_on = 1'b1;
    ext_cmos = 1'b0;
    ext_xtal = 1'b0;
    ext_div2 = 1'b0;
    // crystal, rc, capacitor and cmos sources
    case (new_mode)
      `LFO_XM_OFF0: ext_on = 1'b0;
      `LFO_XM_OFF1: ext_on = 1'b0;
      `LFO_XM_CMOS: ext_cmos = 1'b1;
      `LFO_XM_CMOS_D2: begin
        ext_cmos = 1'b1;
        ext_div2 = 1'b1;
      end
      `LFO_XM_RC_D2: ext_div2 = 1'b1;
      `LFO_XM_CAP_D2: ext_div2 = 1'b1;
      `LFO_XM_XTAL: ext_xtal = 1'b1;
      `LFO_XM_XTAL_D2: begin
        ext_xtal = 1'b1;
        ext_div2 = 1'b1;
      end
      default: ext_on = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // external drive outputs, pins, valid flag, clock
  // ----------------------------------------------------------------
  // registered pin claims and status
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_drive_en <= 1'b0;
      ext_osc_pin_a <= 1'b0;
      ext_osc_pin_b <= 1'b0;
      ext_osc_valid_flag <= 1'b0;
    end else begin
      ext_drive_en <= ext_on && !ext_cmos;
      ext_osc_pin_a <= ext_on && ext_xtal;
      // every active mode takes the second pin
      ext_osc_pin_b <= ext_on;
      // zero when off or in cmos modes
      ext_osc_valid_flag <= ext_on && !ext_cmos && ext_osc_stable;
    end
  end

  // external clock, halved in the divide-by-2 modes
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_raw_q <= 1'b0;
      ext_half_q <= 1'b0;
      ext_clk_out <= 1'b0;
    end else begin
      ext_raw_q <= ext_osc_raw;
      if (!ext_on) begin
        ext_half_q <= 1'b0;
      end else if (ext_osc_raw && !ext_raw_q) begin
        ext_half_q <= !ext_half_q;
      end
      // clock offered to system and peripherals
      ext_clk_out <= ext_on && (ext_div2 ? ext_half_q : ext_raw_q);
    end
  end

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  // read mux; unmapped addresses and unused bits read zero
  always @* begin
    rd_mux = 8'h00;
    case (sfr_addr)
      `LFO_ADDR_LF_CTRL: begin
        rd_mux[`LFO_LF_EN_BIT] = lowfreq_osc_enable;
        rd_mux[`LFO_LF_RDY_BIT] = lowfreq_osc_ready;
        rd_mux[`LFO_LF_TUNE_HI:`LFO_LF_TUNE_LO] = lowfreq_fine_tune;
        rd_mux[`LFO_LF_DIV_HI:`LFO_LF_DIV_LO] = lowfreq_divider_select;
      end
      `LFO_ADDR_EXT_CTRL: begin
        rd_mux[`LFO_EXT_VLD_BIT] = ext_osc_valid_flag;
        rd_mux[`LFO_EXT_MODE_HI:`LFO_EXT_MODE_LO] = ext_osc_mode_select;
        rd_mux[`LFO_EXT_FREQ_HI:`LFO_EXT_FREQ_LO] = ext_freq_ctrl;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // read data registered one cycle after the strobe
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

endmodule

//--- core/lfo_consts.vh
`ifndef LFO_CONSTS_VH
`define LFO_CONSTS_VH

// ----------------------------------------------------------------
// register addresses in the special-function register space
// ----------------------------------------------------------------
`define LFO_ADDR_LF_CTRL 8'h86
`define LFO_ADDR_EXT_CTRL 8'hB1

// ----------------------------------------------------------------
// low-frequency control field positions
// ----------------------------------------------------------------
`define LFO_LF_EN_BIT 7
`define LFO_LF_RDY_BIT 6
`define LFO_LF_TUNE_HI 5
`define LFO_LF_TUNE_LO 2
`define LFO_LF_DIV_HI 1
`define LFO_LF_DIV_LO 0

// ----------------------------------------------------------------
// divider select codes
// ----------------------------------------------------------------
`define LFO_DIV_8 2'h0
`define LFO_DIV_4 2'h1
`define LFO_DIV_2 2'h2
`define LFO_DIV_1 2'h3

// ----------------------------------------------------------------
// external control field positions
// ----------------------------------------------------------------
`define LFO_EXT_VLD_BIT 7
`define LFO_EXT_MODE_HI 6
`define LFO_EXT_MODE_LO 4
`define LFO_EXT_FREQ_HI 2
`define LFO_EXT_FREQ_LO 0

// ----------------------------------------------------------------
// external mode codes (000 and 001 both mean off)
// ----------------------------------------------------------------
`define LFO_XM_OFF0 3'h0
`define LFO_XM_OFF1 3'h1
`define LFO_XM_CMOS 3'h2
`define LFO_XM_CMOS_D2 3'h3
`define LFO_XM_RC_D2 3'h4
`define LFO_XM_CAP_D2 3'h5
`define LFO_XM_XTAL 3'h6
`define LFO_XM_XTAL_D2 3'h7

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define LFO_LF_EN_RST 1'h0
`define LFO_LF_DIV_RST 2'h0
`define LFO_LF_TUNE_RST 4'h8
`define LFO_EXT_MODE_RST 3'h0
`define LFO_EXT_FREQ_RST 3'h0
`define LFO_STAB_EDGES 16

`endif

//--- tb/lfo_ctrl_chk.sv
`timescale 1ns/10ps
module lfo_ctrl_chk (
  input wire mclk,
  input wire rstn,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire ext_osc_stable,
  input wire lowfreq_osc_enable,
  input wire [3:0] lowfreq_fine_tune,
  input wire lowfreq_osc_ready,
  input wire lf_clk_out,
  input wire ext_drive_en,
  input wire [2:0] ext_osc_mode_select,
  input wire ext_osc_valid_flag,
  input wire ext_osc_pin_a,
  input wire ext_osc_pin_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // lf and ext control writes
  wire lw = sfr_wr && sfr_addr == 8'h86;
  wire xw = sfr_wr && sfr_addr == 8'hB1;
  wire [2:0] m = ext_osc_mode_select;
  reg [1:0] div_q; // shadow of the divider field
  reg clr_q; // a fall of ready is allowed now
  // shadow divider, flag changed-divider writes and resets
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 2'h0;
      clr_q <= 1'b1;
    end else begin
      clr_q <= lw && sfr_wdata[1:0] != div_q;
      if (lw) begin
        div_q <= sfr_wdata[1:0];
      end
    end
  end
  property p_en;
    lw |=> lowfreq_osc_enable == $past(sfr_wdata[7]);
  endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_off;
    !lowfreq_osc_enable [*4] |-> !lf_clk_out;
  endproperty
  a_off: assert property (p_off) else $error("lf clk off");
  property p_hold;
    $fell(lowfreq_osc_ready) |-> clr_q;
  endproperty
  a_hold: assert property (p_hold) else $error("ready fell");
  property p_rise;
    $rose(lowfreq_osc_ready) |-> $past(lowfreq_osc_enable);
  endproperty
  a_rise: assert property (p_rise) else $error("ready rose");
  property p_tune;
    lw |=> lowfreq_fine_tune == $past(sfr_wdata[5:2]);
  endproperty
  a_tune: assert property (p_tune) else $error("tune");
  property p_mode;
    xw |=> m == $past(sfr_wdata[6:4]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_pins;
    ext_osc_pin_a == $past(m[2:1] == 2'h3) &&
      ext_osc_pin_b == $past(m[2:1] != 2'h0);
  endproperty
  a_pins: assert property (p_pins) else $error("pins");
  property p_vld;
    ext_osc_valid_flag == $past(m[2] && ext_osc_stable) &&
      ext_drive_en == $past(m[2]);
  endproperty
  a_vld: assert property (p_vld) else $error("valid");
  property p_rd;
    sfr_rd && sfr_addr == 8'h86 |=> sfr_rdata == {$past(lowfreq_osc_enable),
      $past(lowfreq_osc_ready), $past(lowfreq_fine_tune), $past(div_q)};
  endproperty
  a_rd: assert property (p_rd) else $error("lf read");
  property p_unm;
    sfr_rd && sfr_addr != 8'h86 && sfr_addr != 8'hB1 |=> sfr_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
endmodule
bind lfo_ctrl lfo_ctrl_chk i_lfo_ctrl_chk (.*);

//--- tb/lfo_osc_model.sv
`timescale 1ns/10ps
module lfo_osc_model (
  input wire mclk,
  input wire lowfreq_osc_enable,
  input wire [3:0] lowfreq_fine_tune,
  input wire [2:0] ext_osc_mode_select,
  input wire ext_drive_en,
  output reg lf_osc_raw,
  output reg ext_osc_raw,
  output reg ext_osc_stable
);
  reg [4:0] lc; // lf half-period count
  reg [3:0] sc; // start-up count
  reg [1:0] ec; // ext clock phase
  initial begin
    {lf_osc_raw, ext_osc_raw, ext_osc_stable, lc, sc, ec} = 0;
  end
  // lf runs slower with larger trim low two bits, stands while off
  always @(posedge mclk) begin
    ec <= ec + 2'h1;
    if (!lowfreq_osc_enable) begin
      lf_osc_raw <= 1'b0;
      lc <= 5'h0;
    end else if (lc >= {3'h0, lowfreq_fine_tune[1:0]} + 5'h2) begin
      lf_osc_raw <= !lf_osc_raw;
      lc <= 5'h0;
    end else begin
      lc <= lc + 5'h1;
    end
    // released pin when off flips every cycle
    ext_osc_raw <= ext_osc_mode_select[2:1] == 2'h0 ? !ext_osc_raw : ec[1];
    sc <= !ext_drive_en ? 4'h0 : (sc == 4'hF ? sc : sc + 4'h1);
    ext_osc_stable <= sc >= 4'h8;
  end
endmodule

//--- tb/tb_lfo_ctrl.sv
`timescale 1ns/10ps
module tb_lfo_ctrl;
  reg mclk, rstn, sfr_wr, sfr_rd;
  reg [7:0] sfr_addr, sfr_wdata, r;
  wire [7:0] sfr_rdata;
  wire lf_osc_raw, ext_osc_raw, ext_osc_stable, lowfreq_osc_enable;
  wire lowfreq_osc_ready, lf_clk_out, ext_drive_en, ext_osc_valid_flag;
  wire ext_osc_pin_a, ext_osc_pin_b, ext_clk_out;
  wire [3:0] lowfreq_fine_tune;
  wire [2:0] ext_osc_mode_select, ext_freq_ctrl;
  integer n_mismatch, n_checks, cyc, i, k, c, n, e, lp, cp;
  reg [31:0] seed;
  lfo_ctrl #(.STAB_EDGES(2)) i_lfo_ctrl (.*);
  lfo_osc_model i_lfo_osc_model (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // expected ext clock rises in a 40-cycle window for a mode
  function integer ext_rises(input [2:0] m);
    begin
      if (m[2:1] == 2'h0) ext_rises = 0;
      else if (m == 3'h2 || m == 3'h6) ext_rises = 10;
      else ext_rises = 5;
    end
  endfunction
  task chk(input [7:0] g, input [7:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
      @(posedge mclk);
      sfr_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] x);
    begin
      @(posedge mclk);
      {sfr_rd, sfr_addr} <= {1'b1, a};
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1 chk(sfr_rdata, x);
    end
  endtask
  task print_verdict;
    begin
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 0;
    {n_mismatch, n_checks, cyc} = 0;
    seed = 45;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h86, 8'h20);
    rd(8'hB1, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    // trims only while stopped, corners first
    // trim while disabled
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      r = i == 0 ? 8'h00 : (i == 1 ? 8'h3C : seed[7:0] & 8'h3F);
      wr(8'h86, r);
      rd(8'h86, r);
      chk(lowfreq_fine_tune, r[5:2]);
    end
    wr(8'h86, 8'h04);
    // each divider: restart, ready, output ratio
    for (k = 0; k < 4; k = k + 1) begin
      wr(8'h86, 8'h84 | k[1:0]);
      chk(lowfreq_osc_ready, 0);
      for (c = 0; c < 500 && !lowfreq_osc_ready; c = c + 1) @(posedge mclk);
      #1 chk(lowfreq_osc_ready, 1);
      rd(8'h86, 8'hC4 | k[1:0]);
      {n, i, lp, cp} = 0;
      while (i < 32) begin
        @(posedge mclk);
        #1;
        i = i + (lf_osc_raw && !lp);
        n = n + (lf_clk_out && !cp);
        lp = lf_osc_raw;
        cp = lf_clk_out;
      end
      e = 32 >> (3 - k);
      chk(n >= e - 1 && n <= e + 1, 1);
    end
    wr(8'h86, 8'h87);
    chk(lowfreq_osc_ready, 1);
    wr(8'h86, 8'h07);
    repeat (6) @(posedge mclk);
    #1 chk({lowfreq_osc_ready, lf_clk_out}, 2);
    // mid-run reset: sticky ready must fall back to zero
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h86, 8'h20);
    for (k = 0; k < 8; k = k + 1) begin
      seed = xs(seed);
      r = {1'b0, k[2:0], 1'b0, seed[2:0]};
      wr(8'hB1, r);
      repeat (16) @(posedge mclk);
      #1 chk({ext_osc_pin_a, ext_osc_pin_b, ext_drive_en, ext_osc_valid_flag},
        {k[2:1] == 3, k[2:1] != 0, k[2], k[2]});
      chk(ext_freq_ctrl, r[2:0]);
      rd(8'hB1, r | {k[2], 7'h0});
      {n, cp} = 0;
      repeat (40) begin
        @(posedge mclk);
        #1;
        n = n + (ext_clk_out && !cp);
        cp = ext_clk_out;
      end
      e = ext_rises(r[6:4]);
      chk(n + 1 >= e && n <= e + 1, 1);
    end
    print_verdict;
  end
endmodule
